// ===== verilog/smpo_defines.svh
// Function
// - Channel A mode from bits 5, 8, 14: off, internal or external PLL.
// - Channel B mode from bits 6, 9, 15, decoded as for channel A.
// - Channel A phase offset bits 23:20, code n is n*30 deg for 0h-Bh.
// - Channel B phase offset bits 31:28, code n is n*30 deg for 0h-Bh.
// - Driven sync output is high 40 to 60 percent of its period.
`ifndef SMPO_DEFINES_SVH
`define SMPO_DEFINES_SVH

// Register byte addresses
`define SMPO_ADDR_CFG 8'h00
`define SMPO_ADDR_STAT 8'h04
`define SMPO_ADDR_FREE 8'h08
`define SMPO_ADDR_MEAS 8'h0c

// Reset values and the counter saturation value
`define SMPO_CFG_RST 32'h0000_0000
`define SMPO_FREE_RST 12'h0c8
`define SMPO_PER_SAT 12'hfff

// Configuration field positions
`define SMPO_A_EXT 5
`define SMPO_B_EXT 6
`define SMPO_A_INT 8
`define SMPO_B_INT 9
`define SMPO_A_PLL 14
`define SMPO_B_PLL 15
`define SMPO_A_PH_HI 23
`define SMPO_A_PH_LO 20
`define SMPO_B_PH_HI 31
`define SMPO_B_PH_LO 28

// Phase steps: twelve steps of 30 degrees
`define SMPO_PH_MAX 4'hb
`define SMPO_PH_STEPS 16'h000c

// Frequencies in their own units and derived cycle counts
`define SMPO_CLK_MHZ 200
`define SMPO_SYNC_MIN_KHZ 200
`define SMPO_SYNC_MAX_KHZ 2000
`define SMPO_SYNC_TOL_KHZ 50
`define SMPO_PER_MAX (12'((`SMPO_CLK_MHZ * 1000) / `SMPO_SYNC_MIN_KHZ))
`define SMPO_PER_MIN (12'((`SMPO_CLK_MHZ * 1000) / `SMPO_SYNC_MAX_KHZ))
`define SMPO_TOL_SCALE (24'((`SMPO_CLK_MHZ * 1000) / `SMPO_SYNC_TOL_KHZ))

// Bus responses
`define SMPO_RESP_OKAY 2'b00
`define SMPO_RESP_SLVERR 2'b10

`endif

// ===== verilog/smpo_pkg.sv
`default_nettype none
package smpo_pkg;

  typedef logic [31:0] smpo_word_t;
  typedef logic [7:0] smpo_addr_t;
  typedef logic [3:0] smpo_strb_t;
  typedef logic [11:0] smpo_per_t;
  typedef enum logic [1:0] {mode_dis, mode_int, mode_ext, mode_rsv} smpo_mode_t;

  // Mode decode of one channel from its three configuration bits
  function automatic smpo_mode_t smpo_decode(input logic ext_b,
                                             input logic int_b,
                                             input logic pll_b);
    smpo_mode_t m;
    if (!int_b && !pll_b)
      m = mode_dis;
    else if (int_b && !ext_b && !pll_b)
      m = mode_int;
    else if (ext_b && pll_b && !int_b)
      m = mode_ext;
    else
      m = mode_rsv;
    return m;
  endfunction : smpo_decode

endpackage : smpo_pkg
`default_nettype wire

// ===== verilog/smpo_ch_if.sv
`timescale 1ns/10ps
`default_nettype none
interface smpo_ch_if;
  logic ref_tick;
  smpo_pkg::smpo_per_t ref_period;
  logic [3:0] code;
  logic run;
  logic ch_clk;

  modport ctrl (output ref_tick, ref_period, code, run, input ch_clk);
  modport gen (input ref_tick, ref_period, code, run, output ch_clk);
endinterface : smpo_ch_if
`default_nettype wire

// ===== verilog/smpo_phase_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "smpo_defines.svh"
module smpo_phase_gen (
  input wire logic core_clk,
  input wire logic nrst,
  smpo_ch_if.gen chn
);
  import smpo_pkg::*;

  smpo_per_t pos_reg, pos_next;
  logic clk_reg, clk_next;
  logic [3:0] code_eff;
  logic [15:0] prod;
  smpo_per_t target, half, shifted;

  // Delay from reference edge is period times code over twelve
  always_comb
  begin
    // Reserved codes fall back to zero offset
    code_eff = (chn.code > `SMPO_PH_MAX) ? 4'h0 : chn.code;
    prod = 16'(chn.ref_period) * 16'(code_eff);
    target = 12'(prod / `SMPO_PH_STEPS);
    half = chn.ref_period >> 1;
    if (pos_reg >= target)
      shifted = pos_reg - target;
    else
      shifted = 12'({1'b0, pos_reg} + {1'b0, chn.ref_period} - {1'b0, target});
    // Saturate so a lost reference cannot wrap the position
    if (chn.ref_tick)
      pos_next = 12'h000;
    else if (pos_reg == `SMPO_PER_SAT)
      pos_next = pos_reg;
    else
      pos_next = pos_reg + 12'h001;
    clk_next = chn.run && (shifted < half);
  end

  // Position and channel clock registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pos_reg <= 12'h000;
      clk_reg <= 1'b0;
    end
    else
    begin
      pos_reg <= pos_next;
      clk_reg <= clk_next;
    end
  end

  assign chn.ch_clk = clk_reg;

  a_phase_rise_at: assert property (
    @(posedge core_clk) disable iff (!nrst)
    chn.run && pos_reg == target && half != 12'h000 |=> clk_reg)
    else $error("channel clock did not rise at phase offset");

  a_phase_fall_at: assert property (
    @(posedge core_clk) disable iff (!nrst)
    shifted == half |=> !clk_reg)
    else $error("channel clock did not fall at half period");

endmodule : smpo_phase_gen
`default_nettype wire

// ===== verilog/smpo_top.sv
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "smpo_defines.svh"
module smpo_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire smpo_pkg::smpo_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire smpo_pkg::smpo_word_t s_axi_wdata,
  input wire smpo_pkg::smpo_strb_t s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire smpo_pkg::smpo_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output smpo_pkg::smpo_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe_n,
  output logic ch_a_clk,
  output logic ch_b_clk
);
  import smpo_pkg::*;

  // Register file and bus state
  smpo_word_t cfg_reg, cfg_next;
  smpo_per_t free_reg, free_next;
  logic aw_have_reg, aw_have_next;
  smpo_addr_t aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next;
  smpo_word_t w_data_reg, w_data_next;
  smpo_strb_t w_strb_reg, w_strb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  smpo_word_t rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Sync pin timing state
  logic s1_reg, s2_reg, s3_reg;
  smpo_per_t meas_cnt_reg, meas_cnt_next;
  smpo_per_t meas_per_reg, meas_per_next;
  logic seen_reg, seen_next;
  logic sync_ok_reg, sync_ok_next;
  smpo_per_t int_cnt_reg, int_cnt_next;
  logic sync_out_reg, sync_out_next;
  logic sync_oe_n_reg, sync_oe_n_next;

  smpo_mode_t mode_a, mode_b;
  logic any_ext, any_int, drive, sync_rise, int_tick, in_range, in_tol;
  logic use_ext_a, use_ext_b, do_write;
  smpo_per_t diff, half_free;
  logic [23:0] lhs, rhs;
  smpo_word_t stat_word;

  smpo_ch_if ch_a_if ();
  smpo_ch_if ch_b_if ();

  // Mode decode and pin direction; any external mode makes the pin an input
  always_comb
  begin
    mode_a = smpo_decode(cfg_reg[`SMPO_A_EXT], cfg_reg[`SMPO_A_INT],
                         cfg_reg[`SMPO_A_PLL]);
    mode_b = smpo_decode(cfg_reg[`SMPO_B_EXT], cfg_reg[`SMPO_B_INT],
                         cfg_reg[`SMPO_B_PLL]);
    any_ext = (mode_a == mode_ext) || (mode_b == mode_ext);
    any_int = (mode_a == mode_int) || (mode_b == mode_int);
    drive = any_int && !any_ext;
  end

  // Period check in cross-multiplied form avoids a divider on the sync path
  always_comb
  begin
    sync_rise = s2_reg && !s3_reg;
    half_free = free_reg >> 1;
    if (meas_cnt_reg > free_reg)
      diff = meas_cnt_reg - free_reg;
    else
      diff = free_reg - meas_cnt_reg;
    lhs = 24'(diff) * `SMPO_TOL_SCALE;
    rhs = 24'(meas_cnt_reg) * 24'(free_reg);
    in_range = (meas_cnt_reg >= `SMPO_PER_MIN) &&
               (meas_cnt_reg <= `SMPO_PER_MAX);
    in_tol = lhs <= rhs;
    meas_cnt_next = meas_cnt_reg;
    meas_per_next = meas_per_reg;
    seen_next = seen_reg;
    sync_ok_next = sync_ok_reg;
    if (!any_ext)
    begin
      seen_next = 1'b0;
      sync_ok_next = 1'b0;
      meas_cnt_next = 12'h000;
    end
    else if (sync_rise)
    begin
      meas_cnt_next = 12'h001;
      meas_per_next = meas_cnt_reg;
      seen_next = 1'b1;
      sync_ok_next = seen_reg && in_range && in_tol;
    end
    else
    begin
      if (meas_cnt_reg != `SMPO_PER_SAT)
        meas_cnt_next = meas_cnt_reg + 12'h001;
      // A source that stops is dropped once it is slower than the floor
      if (meas_cnt_reg > `SMPO_PER_MAX)
        sync_ok_next = 1'b0;
    end
    if (({1'b0, int_cnt_reg} + 13'h0001) >= {1'b0, free_reg})
      int_cnt_next = 12'h000;
    else
      int_cnt_next = int_cnt_reg + 12'h001;
    int_tick = int_cnt_reg == 12'h000;
    sync_out_next = drive && (int_cnt_next < half_free);
    sync_oe_n_next = !drive;
  end

  // Sync synchroniser, period capture and internal timebase
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      meas_cnt_reg <= 12'h000;
      meas_per_reg <= 12'h000;
      seen_reg <= 1'b0;
      sync_ok_reg <= 1'b0;
      int_cnt_reg <= 12'h000;
      sync_out_reg <= 1'b0;
      sync_oe_n_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= sync_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      meas_cnt_reg <= meas_cnt_next;
      meas_per_reg <= meas_per_next;
      seen_reg <= seen_next;
      sync_ok_reg <= sync_ok_next;
      int_cnt_reg <= int_cnt_next;
      sync_out_reg <= sync_out_next;
      sync_oe_n_reg <= sync_oe_n_next;
    end
  end

  // Channel references: a locked external clock, else the internal timebase
  always_comb
  begin
    use_ext_a = (mode_a == mode_ext) && sync_ok_reg;
    use_ext_b = (mode_b == mode_ext) && sync_ok_reg;
    ch_a_if.run = (mode_a == mode_int) || (mode_a == mode_ext);
    ch_b_if.run = (mode_b == mode_int) || (mode_b == mode_ext);
    ch_a_if.ref_tick = use_ext_a ? sync_rise : int_tick;
    ch_b_if.ref_tick = use_ext_b ? sync_rise : int_tick;
    ch_a_if.ref_period = use_ext_a ? meas_per_reg : free_reg;
    ch_b_if.ref_period = use_ext_b ? meas_per_reg : free_reg;
    ch_a_if.code = cfg_reg[`SMPO_A_PH_HI:`SMPO_A_PH_LO];
    ch_b_if.code = cfg_reg[`SMPO_B_PH_HI:`SMPO_B_PH_LO];
  end

  smpo_phase_gen u_gen_a (
    .core_clk(core_clk),
    .nrst(nrst),
    .chn(ch_a_if.gen)
  );

  smpo_phase_gen u_gen_b (
    .core_clk(core_clk),
    .nrst(nrst),
    .chn(ch_b_if.gen)
  );

  // Bus slave: address and data latched apart, written once both are held
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[1:0] = mode_a;
    stat_word[3:2] = mode_b;
    stat_word[4] = sync_ok_reg;
    stat_word[5] = drive;
    cfg_next = cfg_reg;
    free_next = free_reg;
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    if (do_write)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `SMPO_RESP_OKAY;
      if (aw_addr_reg == `SMPO_ADDR_CFG)
      begin
        for (int i = 0; i < 4; i++)
          if (w_strb_reg[i])
            cfg_next[i*8 +: 8] = w_data_reg[i*8 +: 8];
      end
      else if (aw_addr_reg == `SMPO_ADDR_FREE)
      begin
        if (w_strb_reg[0])
          free_next[7:0] = w_data_reg[7:0];
        if (w_strb_reg[1])
          free_next[11:8] = w_data_reg[11:8];
      end
      else if (aw_addr_reg == `SMPO_ADDR_STAT ||
               aw_addr_reg == `SMPO_ADDR_MEAS)
        bresp_next = `SMPO_RESP_OKAY;
      else
        bresp_next = `SMPO_RESP_SLVERR;
    end
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && arready_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next = `SMPO_RESP_OKAY;
      if (s_axi_araddr == `SMPO_ADDR_CFG)
        rdata_next = cfg_reg;
      else if (s_axi_araddr == `SMPO_ADDR_STAT)
        rdata_next = stat_word;
      else if (s_axi_araddr == `SMPO_ADDR_FREE)
        rdata_next = {20'h00000, free_reg};
      else if (s_axi_araddr == `SMPO_ADDR_MEAS)
        rdata_next = {20'h00000, meas_per_reg};
      else
      begin
        rdata_next = 32'h0000_0000;
        rresp_next = `SMPO_RESP_SLVERR;
      end
    end
    arready_next = !rvalid_next;
  end

  // Register file and bus handshake registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cfg_reg <= `SMPO_CFG_RST;
      free_reg <= `SMPO_FREE_RST;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SMPO_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SMPO_RESP_OKAY;
    end
    else
    begin
      cfg_reg <= cfg_next;
      free_reg <= free_next;
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign sync_out = sync_out_reg;
  assign sync_oe_n = sync_oe_n_reg;
  assign ch_a_clk = ch_a_if.ch_clk;
  assign ch_b_clk = ch_b_if.ch_clk;

  a_chan_a_off: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (mode_a == mode_dis)[*3] |-> !ch_a_clk)
    else $error("channel A clock runs while disabled");

  a_chan_b_off: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (mode_b == mode_dis)[*3] |-> !ch_b_clk)
    else $error("channel B clock runs while disabled");

  a_pin_input_ext: assert property (
    @(posedge core_clk) disable iff (!nrst)
    any_ext |=> sync_oe_n && !sync_out)
    else $error("sync pin driven in external mode");

  a_pin_drive_int: assert property (
    @(posedge core_clk) disable iff (!nrst)
    any_int && !any_ext |=> !sync_oe_n)
    else $error("sync pin not driven in internal mode");

  a_sync_out_high: assert property (
    @(posedge core_clk) disable iff (!nrst)
    drive && $stable(drive) && int_cnt_reg == 12'h000 &&
    half_free != 12'h000 |-> sync_out_reg)
    else $error("sync output low at start of period");

  a_sync_out_low: assert property (
    @(posedge core_clk) disable iff (!nrst)
    int_cnt_reg == half_free |-> !sync_out_reg)
    else $error("sync output high past half period");

  a_lock_in_range: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(sync_ok_reg) |-> meas_per_reg >= `SMPO_PER_MIN &&
    meas_per_reg <= `SMPO_PER_MAX)
    else $error("lock taken outside sync frequency range");

  a_write_answer: assert property (
    @(posedge core_clk) disable iff (!nrst)
    aw_have_reg && w_have_reg && !bvalid_reg |=> bvalid_reg)
    else $error("write response late");

  a_read_answer: assert property (
    @(posedge core_clk) disable iff (!nrst)
    s_axi_arvalid && arready_reg |=> rvalid_reg ##0 !arready_reg)
    else $error("read data late");

endmodule : smpo_top
`default_nettype wire

// ===== verif/smpo_sync_src.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side clock source feeding the sync pin
module smpo_sync_src #(
  parameter int HALF_NS = 504
) (
  input wire logic run,
  output logic pin
);
  // Starts a new period only while run is high and finishes it, else stands low like a stopped source
  initial pin = 1'b0;
  always
  begin
    if (run)
    begin
      #(HALF_NS) pin = 1'b1;
      #(HALF_NS) pin = 1'b0;
    end
    else
    begin
      pin = 1'b0;
      #48;
    end
  end
endmodule : smpo_sync_src
`default_nettype wire

// ===== verif/sync_mode_phase_offset_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "smpo_defines.svh"
module sync_mode_phase_offset_ctrl_bench;
  import smpo_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0;
  smpo_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  smpo_word_t s_axi_wdata = 32'h0, s_axi_rdata;
  smpo_strb_t s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, src_run = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sync_out, sync_oe_n, ch_a_clk, ch_b_clk, src_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic sync_pin;
  int err_total = 0, total_checks = 0, cyc = 0;
  int a_rise = 0, b_rise = 0, a_n = 0, s_rise = 0, s_per = 0, s_high = 0;
  logic a_q = 1'b0, b_q = 1'b0, s_q = 1'b0;
  localparam int LIMIT = 60000;

  // Pin level from whichever party drives it
  assign sync_pin = (sync_oe_n === 1'b0) ? sync_out : src_pin;
  always #2.5 core_clk = ~core_clk;

  smpo_top uut (.core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sync_in(sync_pin), .sync_out(sync_out),
    .sync_oe_n(sync_oe_n), .ch_a_clk(ch_a_clk), .ch_b_clk(ch_b_clk));

  // 1008 ns period, about 992 kHz, inside 50 kHz of the 1 MHz free run
  smpo_sync_src #(.HALF_NS(504)) src (.run(src_run), .pin(src_pin));

  // Edge bookkeeping in cycles; a hang counts as a mismatch
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    a_q <= ch_a_clk;
    b_q <= ch_b_clk;
    s_q <= sync_out;
    if (ch_a_clk && !a_q)
    begin
      a_rise <= cyc;
      a_n <= a_n + 1;
    end
    if (ch_b_clk && !b_q)
      b_rise <= cyc;
    if (sync_out && !s_q)
    begin
      s_rise <= cyc;
      s_per <= cyc - s_rise;
    end
    if (!sync_out && s_q)
      s_high <= cyc - s_rise;
    if (cyc == LIMIT)
    begin
      err_total++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write master: address and data offered together, each released when taken
  task automatic axi_write(input smpo_addr_t a, input smpo_word_t d);
    logic aw_done, w_done;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done))
    begin
      @(posedge core_clk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, `SMPO_RESP_OKAY);
  endtask : axi_write

  task automatic axi_read(input smpo_addr_t a, output smpo_word_t d,
                          output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic test_reset;
    smpo_word_t d;
    logic [1:0] r;
    axi_read(`SMPO_ADDR_CFG, d, r);
    check(d, `SMPO_CFG_RST);
    axi_read(`SMPO_ADDR_FREE, d, r);
    check(d, {20'h0, `SMPO_FREE_RST});
    axi_read(8'h10, d, r);
    check(d, 32'h0000_0000);
    check(32'(r), 32'(`SMPO_RESP_SLVERR));
    // Status is read only: a write is answered but changes nothing
    axi_write(`SMPO_ADDR_STAT, 32'hffff_ffff);
    axi_read(`SMPO_ADDR_CFG, d, r);
    check(d, `SMPO_CFG_RST);
    check(sync_oe_n, 1'b1);
    $display("test reset done");
  endtask : test_reset

  // Every pattern of the three bits per channel, channel B given the complement of channel A
  task automatic test_modes;
    smpo_word_t d;
    logic [1:0] r;
    logic [2:0] pa, pb;
    for (int i = 0; i < 8; i++)
    begin
      pa = 3'(i);
      pb = 3'(7 - i);
      d = 32'h0;
      d[5] = pa[2];
      d[8] = pa[1];
      d[14] = pa[0];
      d[6] = pb[2];
      d[9] = pb[1];
      d[15] = pb[0];
      axi_write(`SMPO_ADDR_CFG, d);
      axi_read(`SMPO_ADDR_STAT, d, r);
      check(d[1:0], exp_mode(pa));
      check(d[3:2], exp_mode(pb));
    end
    $display("test modes done");
  endtask : test_modes

  function automatic logic [1:0] exp_mode(input logic [2:0] p);
    if (p[1:0] == 2'b00)
      return 2'd0;
    if (p == 3'b010)
      return 2'd1;
    if (p == 3'b101)
      return 2'd2;
    return 2'd3;
  endfunction : exp_mode

  // Both channels internal, period 120 cycles: one step is 10 cycles
  task automatic test_phase;
    int n0, da, db;
    for (int n = 0; n < 12; n++)
    begin
      axi_write(`SMPO_ADDR_FREE, 32'd120);
      axi_write(`SMPO_ADDR_CFG, 32'h0000_0300 | (32'(n) << 28));
      n0 = a_n;
      while (a_n < n0 + 3)
        @(posedge core_clk);
      db = ((b_rise - a_rise) % 120 + 120) % 120;
      check(db, 10 * n);
      axi_write(`SMPO_ADDR_CFG, 32'h0000_0300 | (32'(n) << 20));
      n0 = a_n;
      while (a_n < n0 + 3)
        @(posedge core_clk);
      da = ((a_rise - b_rise) % 120 + 120) % 120;
      check(da, 10 * n);
    end
    $display("test phase done");
  endtask : test_phase

  // Internal drive of the pin at 200 cycles: high 100, period 200
  task automatic test_duty;
    smpo_word_t d;
    logic [1:0] r;
    axi_write(`SMPO_ADDR_FREE, 32'd200);
    axi_write(`SMPO_ADDR_CFG, 32'h0000_0100);
    repeat (700) @(posedge core_clk);
    axi_read(`SMPO_ADDR_STAT, d, r);
    check({d[5], sync_oe_n}, 2'b10);
    check(s_per, 200);
    check(s_high, 100);
    check(s_high * 10 >= s_per * 4, 1);
    check(s_high * 10 <= s_per * 6, 1);
    $display("test duty done");
  endtask : test_duty

  // External source on channel A: pin released, lock, then loss of lock
  task automatic test_ext;
    smpo_word_t d;
    logic [1:0] r;
    src_run <= 1'b1;
    axi_write(`SMPO_ADDR_CFG, 32'h0000_4020);
    repeat (1000) @(posedge core_clk);
    check({sync_oe_n, sync_out}, 2'b10);
    axi_read(`SMPO_ADDR_STAT, d, r);
    check(d[5:0], 6'h12);
    axi_read(`SMPO_ADDR_MEAS, d, r);
    check(d == 32'd201 || d == 32'd202, 1);
    src_run <= 1'b0;
    // Last edge may come a half period late, then 1000 cycles to drop lock
    repeat (1300) @(posedge core_clk);
    axi_read(`SMPO_ADDR_STAT, d, r);
    check(d[4], 1'b0);
    $display("test ext done");
  endtask : test_ext

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    test_reset();
    test_modes();
    test_phase();
    test_duty();
    test_ext();
    results();
  end
endmodule : sync_mode_phase_offset_ctrl_bench
`default_nettype wire
